/* src/vfe_pkg.sv */
package vfe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets and reset values
  localparam logic [7:0] VFE_OFS_ROUTE  = 8'h00;
  localparam logic [7:0] VFE_OFS_GAIN   = 8'h01;
  localparam logic [7:0] VFE_OFS_STD    = 8'h02;
  localparam logic [7:0] VFE_OFS_OPMODE = 8'h03;

  localparam logic [7:0] VFE_RST_ROUTE  = 8'h00;
  localparam logic [3:0] VFE_RST_GAIN   = 4'hf;
  localparam logic [2:0] VFE_RST_STD    = 3'h0;
  localparam logic [1:0] VFE_RST_LOOP   = 2'h0;
  localparam logic       VFE_RST_PSAVE  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int VFE_GAIN_LUMA_BIT   = 0;
  localparam int VFE_GAIN_CHROMA_BIT = 1;
  localparam int VFE_OPM_PSAVE_BIT   = 0;
  localparam int VFE_OPM_LOOP_LSB    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // input route code fields
  localparam logic [3:0] VFE_RT_HI_CVBS   = 4'h0;
  localparam logic [2:0] VFE_RT_HI_SVID   = 3'h2;
  localparam logic [3:0] VFE_RT_HI_RGB    = 4'h8;
  localparam logic [3:0] VFE_RT_HI_YPBPR  = 4'h9;
  localparam logic [3:0] VFE_RT_HI_SC_RGB = 4'hc;
  localparam logic [3:0] VFE_RT_HI_SC_YUV = 4'hd;
  localparam logic [1:0] VFE_RT_MID_3CH   = 2'h1;
  localparam logic [1:0] VFE_RT_MID_SCART = 2'h3;
  localparam logic [1:0] VFE_RT_LETTER_N  = 2'h3;
  localparam logic [7:0] VFE_RT_SCART0    = 8'hcc;
  localparam logic [3:0] VFE_TERM_G2      = 4'h3;
  localparam logic [3:0] VFE_TERM_G3      = 4'h6;
  localparam logic [3:0] VFE_TERM_G4A     = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // standard and loop response codes
  localparam logic [2:0] VFE_STD_AUTO  = 3'h0;
  localparam logic [2:0] VFE_STD_525   = 3'h1;
  localparam logic [2:0] VFE_STD_625   = 3'h2;
  localparam logic [2:0] VFE_STD_PAL60 = 3'h7;

  localparam logic [1:0] VFE_LOOP_ADAPT  = 2'h0;
  localparam logic [1:0] VFE_LOOP_FAST   = 2'h2;
  localparam logic [1:0] VFE_LOOP_NORMAL = 2'h3;

  localparam logic [7:0] VFE_PSAVE_DIV = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    VFE_MODE_CVBS, VFE_MODE_SVID, VFE_MODE_RGB, VFE_MODE_YPBPR, VFE_MODE_SC_RGB, VFE_MODE_SC_YUV
  } vfe_mode_t;

  typedef struct packed {
    vfe_mode_t  mode;
    logic [3:0] sync_term;
    logic [3:0] chroma_term;
    logic [3:0] red_term;
    logic [3:0] aux_term;
    logic       aux_used;
    logic       supported;
  } vfe_route_t;

  typedef enum logic [3:0] {
    VFE_I2C_IDLE, VFE_I2C_ADDR, VFE_I2C_ACK_A, VFE_I2C_SUB, VFE_I2C_ACK_S,
    VFE_I2C_WDATA, VFE_I2C_ACK_W, VFE_I2C_RDATA, VFE_I2C_RACK
  } vfe_i2c_st_t;

endpackage

/* src/vfe_route_decode.sv */
`timescale 1ns/1ps
module vfe_route_decode (
  input  wire logic [7:0]         code,   // route register value
  output vfe_pkg::vfe_route_t     route   // decoded terminals
);
  import vfe_pkg::*;

  logic [1:0] letter;
  logic       letter_ok;

  always_comb begin
    letter    = code[1:0];
    letter_ok = (letter != VFE_RT_LETTER_N);
    route     = '0;
    route.mode = VFE_MODE_CVBS;
    if (code[7:4] == VFE_RT_HI_CVBS) begin
      // group 4 has only its first terminal
      route.sync_term = (code[3:2] == VFE_RT_MID_SCART) ? VFE_TERM_G4A :
                        4'({code[3:2], 1'b0} + code[3:2]) + 4'(letter);
      route.supported = (code[3:2] == VFE_RT_MID_SCART) ? (letter == 2'h0) : letter_ok;
    end else if (code[7:5] == VFE_RT_HI_SVID && code[2]) begin
      route.mode        = VFE_MODE_SVID;
      route.sync_term   = code[3] ? VFE_TERM_G4A : VFE_TERM_G2 + 4'(letter);
      route.chroma_term = (code[4] ? VFE_TERM_G3 : 4'h0) + 4'(letter);
      route.supported   = letter_ok;
    end else if (code[3:2] == VFE_RT_MID_3CH || code[3:2] == VFE_RT_MID_SCART) begin
      route.chroma_term = 4'(letter);
      route.sync_term   = VFE_TERM_G2 + 4'(letter);
      route.red_term    = VFE_TERM_G3 + 4'(letter);
      route.aux_term    = VFE_TERM_G4A;
      route.supported   = letter_ok;
      case (code[7:4])
        VFE_RT_HI_RGB: begin
          route.mode = VFE_MODE_RGB;
          route.supported = letter_ok && code[3:2] == VFE_RT_MID_3CH;
        end
        VFE_RT_HI_YPBPR: begin
          route.mode = VFE_MODE_YPBPR;
          route.supported = letter_ok && code[3:2] == VFE_RT_MID_3CH;
        end
        VFE_RT_HI_SC_RGB: begin
          route.mode = VFE_MODE_SC_RGB;
          route.aux_used = 1'b1;
          route.supported = letter_ok && code[3:2] == VFE_RT_MID_SCART;
        end
        VFE_RT_HI_SC_YUV: begin
          route.mode = VFE_MODE_SC_YUV;
          route.aux_used = 1'b1;
          route.supported = letter_ok && code[3:2] == VFE_RT_MID_SCART;
        end
        default: route.supported = 1'b0;
      endcase
    end else begin
      route.supported = 1'b0;
    end
  end

endmodule

/* src/vfe_loop_resp.sv */
`timescale 1ns/1ps
module vfe_loop_resp #(
  parameter int           LW     = 4,        // response level width
  parameter logic [7:0]   ERR_TH = 8'h20     // phase error threshold
) (
  input  wire logic          clk,        // system clock
  input  wire logic          arst_n,     // async reset, active low
  input  wire logic [1:0]    mode,       // loop response field
  input  wire logic [7:0]    phase_err,  // measured phase error magnitude
  input  wire logic          line_tick,  // one pulse per line
  output logic [LW-1:0]      level       // 0 slowest, all ones fastest
);
  import vfe_pkg::*;

  typedef struct packed {
    logic [LW-1:0] level;
  } vfe_loop_state_t;

  vfe_loop_state_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    case (mode)
      VFE_LOOP_NORMAL: s_next.level = '0;
      VFE_LOOP_FAST:   s_next.level = '1;
      default: begin
        // reserved code behaves as adaptive
        if (line_tick) begin
          if (phase_err > ERR_TH && s_reg.level != '1)
            s_next.level = s_reg.level + 1'b1;
          else if (phase_err <= ERR_TH && s_reg.level != '0)
            s_next.level = s_reg.level - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign level = s_reg.level;

endmodule

/* src/vfe_front_end_cfg.sv */
`timescale 1ns/1ps
// Summary of operation
// - Route code selects composite 00-0C, S-Video 44-5E, RGB/YPbPr 84-96.
// - SCART codes CC-CE and DC-DE add composite on group-4 terminal.
// - Chroma gain bit 0, or luma manual, makes chroma gain manual.
// - Chroma and luma auto, non-composite route: chroma channel takes sync channel gain.
// - Luma gain bit 0 freezes gain at last automatic value.
// - Luma gain bit 1, chroma bit 0: auto gain acts on embedded-sync channel only.
// - Auto gain touches only the analog front end.
// - Changing the standard field pulses decoder reinitialization.
// - Non-zero standard field forces that standard (only 525 or 625 in RGB, YPbPr and SCART modes); otherwise autoswitch.
// - Autoswitch never selects PAL 60.
// - Loop field: 00 adaptive, 10 fast, 01 reserved.
// - Normal mode holds the loop at slowest response.
// - Fast mode holds the loop at fastest response.
// - Adaptive mode steers response from measured phase error.
// - Power save slows processor clock, stops converters, keeps I2C.
module vfe_front_end_cfg #(
  parameter logic [6:0] DEV_ADDR = 7'h2e,   // bus address
  parameter int         GW       = 8,       // gain word width
  parameter int         LW       = 4        // loop level width
) (
  input  wire logic             clk,             // 40 MHz clock
  input  wire logic             arst_n,          // async reset, active low
  input  wire logic             scl_in,          // I2C clock
  input  wire logic             sda_in,          // I2C data in
  output logic                  sda_out,         // I2C data out, always low
  output logic                  sda_oe,          // I2C data pull-down enable
  input  wire logic [GW-1:0]    auto_gain_in,    // gain from the sync loop
  input  wire logic [2:0]       det_std,         // detected standard
  input  wire logic             det_valid,       // detected standard valid
  input  wire logic [7:0]       phase_err,       // line phase error magnitude
  input  wire logic             line_tick,       // line strobe
  output vfe_pkg::vfe_route_t   route,           // selected terminals
  output logic [GW-1:0]         sync_gain,       // sync channel gain
  output logic [GW-1:0]         chroma_gain,     // chroma channel gain
  output logic                  sync_auto_act,   // sync auto gain running
  output logic                  chroma_auto_act, // chroma auto gain enabled
  output logic [2:0]            std_active,      // standard in use
  output logic                  std_forced,      // standard forced
  output logic                  reinit_pulse,    // reinitialize decoder
  output logic [LW-1:0]         loop_resp,       // line loop response level
  output logic                  adc_en,          // converters enabled
  output logic                  proc_clk_en,     // processor clock enable
  output logic                  power_save       // power save active
);
  import vfe_pkg::*;

  typedef struct packed {
    vfe_i2c_st_t   i2c_st;
    logic          scl_q;
    logic          sda_q;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg;
    logic [7:0]    ptr;
    logic          rw;
    logic          sda_oe;
    logic [7:0]    route_code;
    logic [3:0]    gain_r;
    logic [2:0]    std_r;
    logic [1:0]    loop_r;
    logic          psave;
    vfe_route_t    route;
    logic [GW-1:0] sync_gain;
    logic [GW-1:0] chroma_gain;
    logic          sync_auto_act;
    logic          chroma_auto_act;
    logic [2:0]    std_active;
    logic          std_forced;
    logic          reinit;
    logic [7:0]    div_cnt;
    logic          proc_en;
    logic          adc_en;
  } vfe_state_t;

  vfe_state_t s_reg, s_next;
  vfe_route_t route_dec;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       scl_rise, scl_fall, start_c, stop_c;
  logic       comp_mode, force_ok;
  logic [7:0] div_lim;

  vfe_route_decode u_decode (
    .code  (s_reg.route_code),
    .route (route_dec)
  );

  vfe_loop_resp #(.LW(LW)) u_loop (
    .clk       (clk),
    .arst_n    (arst_n),
    .mode      (s_reg.loop_r),
    .phase_err (phase_err),
    .line_tick (line_tick),
    .level     (loop_resp)
  );

  function automatic logic [7:0] rd_byte(input vfe_state_t s, input logic [7:0] a);
    case (a)
      VFE_OFS_ROUTE:  rd_byte = s.route_code;
      VFE_OFS_GAIN:   rd_byte = {4'h0, s.gain_r};
      VFE_OFS_STD:    rd_byte = {5'h00, s.std_r};
      VFE_OFS_OPMODE: rd_byte = (8'(s.loop_r) << VFE_OPM_LOOP_LSB) | (8'(s.psave) << VFE_OPM_PSAVE_BIT);
      default:        rd_byte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // host port, register file and front-end control
  always_comb begin
    s_next = s_reg;
    wr_en = 1'b0;
    wr_addr = s_reg.ptr;
    wr_data = s_reg.shreg;
    s_next.reinit = 1'b0;
    s_next.scl_q = scl_in;
    s_next.sda_q = sda_in;
    scl_rise = scl_in & ~s_reg.scl_q;
    scl_fall = ~scl_in & s_reg.scl_q;
    start_c = s_reg.scl_q & scl_in & s_reg.sda_q & ~sda_in;
    stop_c = s_reg.scl_q & scl_in & ~s_reg.sda_q & sda_in;
    // port stays alive in power save
    if (start_c) begin
      s_next.i2c_st = VFE_I2C_ADDR;
      s_next.bit_cnt = 4'h0;
      s_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_next.i2c_st = VFE_I2C_IDLE;
      s_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (s_reg.i2c_st)
        VFE_I2C_ADDR, VFE_I2C_SUB, VFE_I2C_WDATA: begin
          s_next.shreg = {s_reg.shreg[6:0], sda_in};
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
        end
        VFE_I2C_RDATA: s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
        VFE_I2C_RACK:  if (sda_in) s_next.i2c_st = VFE_I2C_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (s_reg.i2c_st)
        VFE_I2C_ADDR: if (s_reg.bit_cnt == 4'h8) begin
          s_next.i2c_st = (s_reg.shreg[7:1] == DEV_ADDR) ? VFE_I2C_ACK_A : VFE_I2C_IDLE;
          s_next.sda_oe = (s_reg.shreg[7:1] == DEV_ADDR);
          s_next.rw = s_reg.shreg[0];
        end
        VFE_I2C_SUB: if (s_reg.bit_cnt == 4'h8) begin
          s_next.ptr = s_reg.shreg;
          s_next.sda_oe = 1'b1;
          s_next.i2c_st = VFE_I2C_ACK_S;
        end
        VFE_I2C_WDATA: if (s_reg.bit_cnt == 4'h8) begin
          wr_en = 1'b1;
          s_next.ptr = s_reg.ptr + 8'h01;
          s_next.sda_oe = 1'b1;
          s_next.i2c_st = VFE_I2C_ACK_W;
        end
        VFE_I2C_ACK_A: begin
          s_next.bit_cnt = 4'h0;
          s_next.shreg = rd_byte(s_reg, s_reg.ptr);
          s_next.sda_oe = s_reg.rw & ~s_next.shreg[7];
          s_next.i2c_st = s_reg.rw ? VFE_I2C_RDATA : VFE_I2C_SUB;
        end
        VFE_I2C_ACK_S, VFE_I2C_ACK_W: begin
          s_next.bit_cnt = 4'h0;
          s_next.sda_oe = 1'b0;
          s_next.i2c_st = VFE_I2C_WDATA;
        end
        VFE_I2C_RDATA: begin
          if (s_reg.bit_cnt == 4'h8) begin
            s_next.sda_oe = 1'b0;
            s_next.i2c_st = VFE_I2C_RACK;
          end else begin
            s_next.shreg = {s_reg.shreg[6:0], 1'b0};
            s_next.sda_oe = ~s_reg.shreg[6];
          end
        end
        VFE_I2C_RACK: begin
          s_next.ptr = s_reg.ptr + 8'h01;
          s_next.bit_cnt = 4'h0;
          s_next.shreg = rd_byte(s_reg, s_next.ptr);
          s_next.sda_oe = ~s_next.shreg[7];
          s_next.i2c_st = VFE_I2C_RDATA;
        end
        default: s_next.sda_oe = 1'b0;
      endcase
    end

    // unmapped offsets are acknowledged and dropped
    if (wr_en) begin
      case (wr_addr)
        VFE_OFS_ROUTE: s_next.route_code = wr_data;
        VFE_OFS_GAIN:  s_next.gain_r = wr_data[3:0];
        VFE_OFS_STD: begin
          s_next.reinit = (wr_data[2:0] != s_reg.std_r);
          s_next.std_r = wr_data[2:0];
        end
        VFE_OFS_OPMODE: begin
          s_next.loop_r = wr_data[VFE_OPM_LOOP_LSB +: 2];
          s_next.psave = wr_data[VFE_OPM_PSAVE_BIT];
        end
        default: ;
      endcase
    end

    s_next.route = route_dec;
    // gains steer only the analog front end, never the digital picture controls
    s_next.sync_auto_act = s_reg.gain_r[VFE_GAIN_LUMA_BIT];
    s_next.chroma_auto_act = s_reg.gain_r[VFE_GAIN_CHROMA_BIT] & s_reg.gain_r[VFE_GAIN_LUMA_BIT];
    if (s_reg.gain_r[VFE_GAIN_LUMA_BIT])
      s_next.sync_gain = auto_gain_in;
    if (s_next.chroma_auto_act && s_reg.route.mode != VFE_MODE_CVBS)
      s_next.chroma_gain = auto_gain_in;
    // otherwise both hold their last automatic value

    comp_mode = s_reg.route.mode inside {VFE_MODE_RGB, VFE_MODE_YPBPR, VFE_MODE_SC_RGB, VFE_MODE_SC_YUV};
    force_ok = (s_reg.std_r != VFE_STD_AUTO) &&
               (!comp_mode || s_reg.std_r == VFE_STD_525 || s_reg.std_r == VFE_STD_625);
    s_next.std_forced = force_ok;
    if (force_ok)
      s_next.std_active = s_reg.std_r;
    else if (det_valid && det_std != VFE_STD_AUTO && det_std != VFE_STD_PAL60)
      s_next.std_active = det_std;

    // slow processor clock and stop converters while saving power
    div_lim = s_reg.psave ? VFE_PSAVE_DIV - 8'h01 : 8'h00;
    s_next.adc_en = ~s_reg.psave;
    if (s_reg.div_cnt >= div_lim) begin
      s_next.div_cnt = 8'h00;
      s_next.proc_en = 1'b1;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 8'h01;
      s_next.proc_en = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.i2c_st <= VFE_I2C_IDLE;
      s_reg.scl_q <= 1'b1;
      s_reg.sda_q <= 1'b1;
      s_reg.route_code <= VFE_RST_ROUTE;
      s_reg.gain_r <= VFE_RST_GAIN;
      s_reg.std_r <= VFE_RST_STD;
      s_reg.loop_r <= VFE_RST_LOOP;
      s_reg.psave <= VFE_RST_PSAVE;
      s_reg.adc_en <= 1'b1;
      s_reg.route.mode <= VFE_MODE_CVBS;
      s_reg.route.supported <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s_reg.sda_oe;
  assign route = s_reg.route;
  assign sync_gain = s_reg.sync_gain;
  assign chroma_gain = s_reg.chroma_gain;
  assign sync_auto_act = s_reg.sync_auto_act;
  assign chroma_auto_act = s_reg.chroma_auto_act;
  assign std_active = s_reg.std_active;
  assign std_forced = s_reg.std_forced;
  assign reinit_pulse = s_reg.reinit;
  assign adc_en = s_reg.adc_en;
  assign proc_clk_en = s_reg.proc_en;
  assign power_save = s_reg.psave;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_ROUTE_CVBS: assert property (s_reg.route_code == VFE_RST_ROUTE |=>
    s_reg.route.mode == VFE_MODE_CVBS && s_reg.route.sync_term == 4'h0 && s_reg.route.supported)
    else $error("default route not first group-1 composite");
  AST_ROUTE_SCART: assert property (s_reg.route_code == VFE_RT_SCART0 |=>
    s_reg.route.mode == VFE_MODE_SC_RGB && s_reg.route.aux_term == VFE_TERM_G4A &&
    s_reg.route.red_term == VFE_TERM_G3 && s_reg.route.aux_used)
    else $error("scart route wrong");
  AST_CHROMA_MANUAL: assert property (!s_reg.gain_r[VFE_GAIN_LUMA_BIT] |=>
    !s_reg.chroma_auto_act ##1 $stable(s_reg.chroma_gain) || s_reg.gain_r[VFE_GAIN_LUMA_BIT])
    else $error("chroma auto while luma manual");
  AST_CHROMA_FOLLOW: assert property (s_reg.gain_r[VFE_GAIN_CHROMA_BIT] && s_reg.gain_r[VFE_GAIN_LUMA_BIT] &&
    s_reg.route.mode != VFE_MODE_CVBS |=> s_reg.chroma_gain == $past(auto_gain_in))
    else $error("chroma gain not following sync gain");
  AST_FREEZE: assert property (!s_reg.gain_r[VFE_GAIN_LUMA_BIT] |=> $stable(s_reg.sync_gain))
    else $error("sync gain moved while frozen");
  AST_SYNC_AUTO: assert property (s_reg.gain_r[VFE_GAIN_LUMA_BIT] |=> s_reg.sync_gain == $past(auto_gain_in))
    else $error("sync gain not tracking loop");
  AST_REINIT: assert property (wr_en && wr_addr == VFE_OFS_STD && wr_data[2:0] != s_reg.std_r |=>
    s_reg.reinit ##1 !s_reg.reinit)
    else $error("reinit pulse missing or long");
  AST_FORCE: assert property (s_reg.std_r != VFE_STD_AUTO && s_reg.route.mode == VFE_MODE_CVBS |=>
    s_reg.std_active == $past(s_reg.std_r) && s_reg.std_forced)
    else $error("forced standard not applied");
  AST_NO_PAL60: assert property (s_reg.std_r == VFE_STD_AUTO && s_reg.std_active != VFE_STD_PAL60 |=>
    s_reg.std_active != VFE_STD_PAL60)
    else $error("autoswitch chose pal 60");
  AST_LOOP_NORMAL: assert property (s_reg.loop_r == VFE_LOOP_NORMAL |=> loop_resp == '0)
    else $error("normal loop not slowest");
  AST_LOOP_FAST: assert property (s_reg.loop_r == VFE_LOOP_FAST |=> loop_resp == '1)
    else $error("fast loop not fastest");
  AST_PSAVE: assert property (s_reg.psave ##1 (s_reg.psave && s_reg.proc_en) |=>
    !s_reg.proc_en && !s_reg.adc_en)
    else $error("power save not slowing clock or stopping converters");

  COV_SCART: cover property (s_reg.route.mode == VFE_MODE_SC_YUV && s_reg.route.supported);
  COV_REINIT: cover property (s_reg.reinit);
  COV_PSAVE: cover property (s_reg.psave && s_reg.proc_en);
  COV_READ: cover property (s_reg.i2c_st == VFE_I2C_RACK ##1 s_reg.i2c_st == VFE_I2C_RDATA);

endmodule

/* verification/vfe_host_model.sv */
`timescale 1ns/1ps
module vfe_host_model #(
  parameter logic [6:0] DEV = 7'h2e  // device bus address
) (
  input  wire logic clk,     // system clock
  input  wire logic sda,     // data line as seen on the wire
  output logic      scl,     // bus clock
  output logic      sda_rel  // 1 lets the pull-up win
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // one pin moves per step, two clocks apart, so no step can fake a start or stop
  task automatic step(input logic c, input logic d);
    scl <= c;
    sda_rel <= d;
    repeat (2) @(posedge clk);
  endtask
  // seq(1,0) is a start, seq(0,1) a stop, seq(b,b) one bit
  task automatic seq(input logic a, input logic b);
    step(1'b0, sda_rel);
    step(1'b0, a);
    step(1'b1, a);
    step(1'b1, b);
  endtask
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      seq(d[i], d[i]);
      q[i] = sda;
    end
    seq(nak, nak);
    ack = !sda;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic       k0, k1, k2;
    seq(1'b1, 1'b0);
    xfer({DEV, 1'b0}, 1'b1, x, k0);
    xfer(a, 1'b1, x, k1);
    xfer(a == 8'h01 ? d | 8'h0c : d, 1'b1, x, k2);
    seq(1'b0, 1'b1);
    ok = k0 & k1 & k2;
  endtask
  // pointer set by a write, then a repeated start reads one byte and nacks
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic [7:0] x;
    logic       k;
    seq(1'b1, 1'b0);
    xfer({DEV, 1'b0}, 1'b1, x, k);
    xfer(a, 1'b1, x, k);
    seq(1'b1, 1'b0);
    xfer({DEV, 1'b1}, 1'b1, x, k);
    xfer(8'hff, 1'b1, q, k);
    seq(1'b0, 1'b1);
  endtask
endmodule

/* verification/vfe_front_end_cfg_test.sv */
`timescale 1ns/1ps
module vfe_front_end_cfg_test;
  import vfe_pkg::*;
  localparam logic [6:0]  DA = 7'h2e;
  localparam logic [15:0] GS [5] = '{16'h440f, 16'h440e, 16'h440f, 16'h440d, 16'h000f};
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] ag = 8'h00;
  logic [2:0] det_std = 3'h0;
  logic       det_valid = 1'b0;
  logic [7:0] phase_err = 8'h00;
  logic       line_tick = 1'b0;
  logic       scl, sda_rel, sda, sda_out, sda_oe, sync_auto_act, chroma_auto_act;
  logic       std_forced, reinit_pulse, adc_en, proc_clk_en, power_save;
  logic [7:0] sync_gain, chroma_gain, rm [4] = '{8'h00, 8'h0f, 8'h00, 8'h00};
  logic [7:0] msk [4] = '{8'hff, 8'h0f, 8'h07, 8'h19};
  logic [3:0] loop_resp;
  logic [2:0] std_active;
  vfe_route_t route;
  int         bad_count = 0;
  int         total_checks = 0;
  int         rc = 0;
  int         pc = 0;
  always #12.5 clk = ~clk;
  assign sda = sda_rel & ~sda_oe;  // pull-up wins when nobody pulls low
  always @(posedge clk) begin
    rc <= rc + (reinit_pulse === 1'b1);
    pc <= pc + (proc_clk_en === 1'b1);
  end
  vfe_front_end_cfg #(.DEV_ADDR(DA)) i_dut (
    .clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .auto_gain_in(ag), .det_std, .det_valid,
    .phase_err, .line_tick, .route, .sync_gain, .chroma_gain, .sync_auto_act, .chroma_auto_act,
    .std_active, .std_forced, .reinit_pulse, .loop_resp, .adc_en, .proc_clk_en, .power_save);
  vfe_host_model #(.DEV(DA)) i_host (.clk, .sda, .scl, .sda_rel);
  ////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic k;
    i_host.wr(a, d, k);
    chk("ack", 1'b1, k);
    if (a < 4) rm[a[1:0]] = d & msk[a[1:0]];
  endtask
  task automatic rdc(logic [7:0] a);
    logic [7:0] q;
    i_host.rd(a, q);
    chk("reg", a < 4 ? rm[a[1:0]] : 8'h00, q);
  endtask
  function automatic bit ok_code(logic [7:0] c);
    int l = c[1:0], m = c[3:2], h = c[7:4];
    if (l == 3) return 0;
    if (h == 0) return m < 3 || l == 0;
    if (h == 4 || h == 5) return m == 1 || m == 3;
    if (h == 8 || h == 9) return m == 1;
    return (h == 12 || h == 13) && m == 3;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] c, q;
    logic       k;
    int         l, m, h, g, e, lv, sv;
    void'($urandom(59996));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    wr(8'h10, 8'h5a);
    wr(8'h02, 8'hf8);
    wr(8'h03, 8'he6);
    for (int a = 0; a < 5; a++) rdc(a == 4 ? 8'h10 : 8'(a));
    i_host.seq(1'b1, 1'b0);
    i_host.xfer({~DA, 1'b0}, 1'b1, q, k);
    i_host.seq(1'b0, 1'b1);
    chk("addr_nak", 1'b0, k);
    // every code, so unsupported ones are seen too
    for (int i = 0; i < 256; i++) begin
      c = i[7:0];
      wr(8'h00, c);
      l = c[1:0];
      m = c[3:2];
      h = c[7:4];
      chk("supported", ok_code(c), route.supported);
      if (ok_code(c)) begin
        chk("mode", h == 0 ? VFE_MODE_CVBS : h < 8 ? VFE_MODE_SVID : h == 8 ? VFE_MODE_RGB :
            h == 9 ? VFE_MODE_YPBPR : h == 12 ? VFE_MODE_SC_RGB : VFE_MODE_SC_YUV, route.mode);
        chk("sync", h == 0 ? m * 3 + l : (h < 8 && m == 3) ? 9 : 3 + l, route.sync_term);
        if (h != 0) chk("chroma", h < 8 ? h % 2 * 6 + l : l, route.chroma_term);
        if (h > 7) chk("red", 6 + l, route.red_term);
        chk("aux", h > 11, route.aux_used);
        if (h > 11) chk("aux_term", 9, route.aux_term);
      end
    end
    foreach (GS[j]) begin
      wr(8'h00, GS[j][15:8]);
      wr(8'h01, GS[j][7:0]);
      g = $urandom % 256;
      ag <= g[7:0];
      repeat (3) @(posedge clk);
      if (GS[j][0]) lv = g;
      if (GS[j][1] && GS[j][0] && GS[j][15:8] != 0) e = g;
      chk("sync_gain", lv, sync_gain);
      chk("chroma_gain", e, chroma_gain);
      chk("sync_act", GS[j][0], sync_auto_act);
      chk("chroma_act", GS[j][1] & GS[j][0], chroma_auto_act);
    end
    det_valid <= 1'b1;
    for (int s = 0; s < 9; s++) begin
      sv = s % 8;
      g = 1 + $urandom % 6;
      det_std <= g[2:0];
      e = rc;
      wr(8'h02, sv[7:0]);
      repeat (3) @(posedge clk);
      chk("std", sv ? sv : g, std_active);
      chk("forced", sv != 0, std_forced);
      chk("reinit", e + (s != 0), rc);
    end
    det_std <= 3'h7;
    wr(8'h00, 8'h94);
    wr(8'h02, 8'h03);
    chk("std", g, std_active);
    chk("forced", 1'b0, std_forced);
    wr(8'h03, 8'h18);
    chk("loop", 4'h0, loop_resp);
    wr(8'h03, 8'h10);
    chk("loop", 4'hf, loop_resp);
    lv = 15;
    for (int i = 0; i < 40; i++) begin
      if (i % 20 == 0) wr(8'h03, i ? 8'h08 : 8'h00);
      g = 8'h1f + $urandom % 3;
      phase_err <= g[7:0];
      line_tick <= 1'b1;
      @(posedge clk);
      line_tick <= 1'b0;
      repeat (2) @(posedge clk);
      lv = g > 8'h20 ? (lv < 15 ? lv + 1 : 15) : (lv > 0 ? lv - 1 : 0);
      chk("loop", lv, loop_resp);
    end
    // divider runs free, so a 64 cycle window holds a whole number of pulses
    for (int p = 1; p >= 0; p--) begin
      wr(8'h03, p[7:0]);
      e = pc;
      repeat (64) @(posedge clk);
      chk("proc_clk", e + (p ? 8 : 64), pc);
      chk("adc", !p, adc_en);
      chk("psave", p, power_save);
      chk("sda_out", 8'h00, sda_out);
      rdc(8'h00);
    end
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule
